// ==== src/exc_sequencer.sv ====
`timescale 1ns/1ps
// What this block does
// - Reset: supervisor, no trace, mask seven
// - Reset clears vector base, uses vector zero
// - Reset loads stack then PC, no stacking
// - Reset instruction pulses external reset, continues
// - Encoded request levels; mask blocks lower-equal
// - Pending interrupts taken only at boundaries
// - Accept: copy status, supervisor, no trace, mask
// - Vector read in acknowledge cycle, low byte
// - Autovector request gives level-based vector
// - Faulted acknowledge gives spurious vector, short
// - Push format/offset, PC, status; offset vec*4
// - Level seven unmaskable; edge and comparison
// - Trap, overflow, bounds, zero divide raise exceptions
// - Bad opcodes and 4afa-4afc are illegal
// - 4848-484f: breakpoint cycle, then illegal
// - Line 1010 and 1111 have own vectors
// - Privileged instruction in user state faults
// - Trace bit at start traces the instruction
// - No trace for unexecuted or aborted instruction
// - Forced exception, then trace, then interrupt
// - Aborts start within two cycles, fixed priority
// - Vector address is base plus offset
module exc_sequencer #(
	parameter int RESET_PULSE_CYC = exc_pkg::EXT_RESET_CYC
) (
	// Clock and reset
	input  wire logic             core_clk_i,
	input  wire logic             resetn_i,
	// Interrupt request pins, encoded level
	input  wire logic [2:0]       irq_level_i,
	// Instruction boundary and aborts from the core
	input  exc_pkg::bnd_s         bnd_i,
	input  wire logic             addr_err_i,
	input  wire logic             bus_err_i,
	// Bus unit port
	output exc_pkg::bus_req_s     bus_req_o,
	input  exc_pkg::bus_rsp_s     bus_rsp_i,
	// Restart of the core and external reset
	output logic                  resume_o,
	output logic                  pc_load_o,
	output logic [31:0]           pc_o,
	output logic                  ext_reset_o,
	// Avalon-MM slave
	input  wire logic [7:0]       avs_address_i,
	input  wire logic             avs_read_i,
	input  wire logic             avs_write_i,
	input  wire logic [3:0]       avs_byteenable_i,
	input  wire logic [31:0]      avs_writedata_i,
	output logic [31:0]           avs_readdata_o,
	output logic                  avs_waitrequest_o
);
	typedef struct packed {
		exc_pkg::state_e   st;
		logic [15:0]       sw;
		logic [15:0]       sw_copy;
		logic [31:0]       vbr;
		logic [31:0]       sup_sp;
		logic [31:0]       pc;
		logic [15:0]       fetch;
		logic [7:0]        vec;
		logic [3:0]        fmt;
		logic [2:0]        lvl_prev;
		logic [2:0]        ack_lvl;
		logic              nmi_pend;
		logic              trap_pend;
		logic [7:0]        trap_vec;
		logic              trace_pend;
		logic              t_arm;
		logic              taken;
		logic [15:0]       op;
		logic              op_bad;
		logic [1:0]        cnt;
		logic [7:0]        rst_cnt;
		exc_pkg::bus_req_s bus;
		logic              resume;
		logic              pc_load;
		logic              ext_reset;
		logic              waitreq;
		logic [31:0]       rdata;
	} state_s;

	state_s      s_q;
	state_s      s_d;
	logic [2:0]  lvl;
	logic        irq_take;
	logic        op_bkpt;
	logic        op_ill;
	logic        op_priv;
	logic        rsp_done;
	logic        bus_acc;
	logic [31:0] rd_mux;

	irq_level_sync #(
		.W (3)
	) u_lvl (
		.core_clk_i (core_clk_i),
		.resetn_i   (resetn_i),
		.level_i    (irq_level_i),
		.level_o    (lvl)
	);

	function automatic logic [31:0] merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] be);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = n[8*i +: 8];
		return r;
	endfunction

	// Common first step of every exception entry
	function automatic state_s enter(input state_s s,
		input logic [7:0] v, input logic [3:0] f);
		state_s r;
		r = s;
		r.sw_copy = s.sw;
		r.sw[exc_pkg::SW_S] = 1'b1;
		r.sw[exc_pkg::SW_T] = 1'b0;
		r.vec = v;
		r.fmt = f;
		r.cnt = 2'h0;
		r.taken = 1'b1;
		r.st = exc_pkg::ST_PUSH;
		return r;
	endfunction

	always_comb
	begin
		op_bkpt = (s_q.op & 16'hfff8) == exc_pkg::OP_BKPT;
		op_ill = s_q.op_bad || (s_q.op >= exc_pkg::OP_ILL_LO
			&& s_q.op <= exc_pkg::OP_ILL_HI);
		op_priv = s_q.op == exc_pkg::OP_AND_SW
			|| s_q.op == exc_pkg::OP_EOR_SW
			|| s_q.op == exc_pkg::OP_OR_SW
			|| (s_q.op & 16'hffc0) == exc_pkg::OP_TO_SW
			|| (s_q.op & 16'hffc0) == exc_pkg::OP_FROM_SW
			|| (s_q.op & 16'hfffe) == exc_pkg::OP_CTRL_MOVE
			|| ((s_q.op & 16'hff00) == exc_pkg::OP_ALT_MOVE
			&& s_q.op[7:6] != 2'h3)
			|| (s_q.op & 16'hfff0) == exc_pkg::OP_USTK_MOVE
			|| s_q.op == exc_pkg::OP_RESET
			|| s_q.op == exc_pkg::OP_STOP
			|| s_q.op == exc_pkg::OP_EXC_RETURN;
		// Level seven always beats the mask through the edge flag
		irq_take = s_q.nmi_pend
			|| lvl > s_q.sw[exc_pkg::SW_MASK +: 3];
		rsp_done = s_q.bus.req && bus_rsp_i.done;
		bus_acc = (avs_read_i || avs_write_i) && !s_q.waitreq;
		unique case (avs_address_i)
			exc_pkg::REG_STATUS: rd_mux = {16'h0, s_q.sw};
			exc_pkg::REG_VBR:    rd_mux = s_q.vbr;
			exc_pkg::REG_SUP_SP: rd_mux = s_q.sup_sp;
			exc_pkg::REG_INFO:   rd_mux = {14'h0, s_q.nmi_pend,
				s_q.st != exc_pkg::ST_IDLE, 5'h0, lvl, s_q.vec};
			default:             rd_mux = 32'h0;
		endcase
	end

	always_comb
	begin
		s_d = s_q;
		s_d.resume = 1'b0;
		s_d.pc_load = 1'b0;
		// One wait cycle, then the answer; writes land on that edge
		s_d.waitreq = !((avs_read_i || avs_write_i) && s_q.waitreq);
		if ((avs_read_i || avs_write_i) && s_q.waitreq)
			s_d.rdata = rd_mux;
		if (bus_acc && avs_write_i)
		begin
			unique case (avs_address_i)
				exc_pkg::REG_STATUS: s_d.sw = 16'(merge(
					{16'h0, s_q.sw}, avs_writedata_i,
					avs_byteenable_i));
				exc_pkg::REG_VBR: s_d.vbr = merge(s_q.vbr,
					avs_writedata_i, avs_byteenable_i);
				exc_pkg::REG_SUP_SP: s_d.sup_sp = merge(s_q.sup_sp,
					avs_writedata_i, avs_byteenable_i);
				default: s_d.rdata = s_q.rdata;
			endcase
		end
		unique case (s_q.st)
			exc_pkg::ST_RSTVEC:
			begin
				if (!s_q.bus.req)
				begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b0;
					s_d.bus.kind = exc_pkg::KIND_DATA;
					s_d.bus.addr = exc_pkg::RST_VEC_ADDR
						+ {29'h0, s_q.cnt, 1'b0};
				end
				else if (bus_rsp_i.done)
				begin
					s_d.bus.req = 1'b0;
					s_d.fetch = bus_rsp_i.rdata;
					s_d.cnt = s_q.cnt + 2'h1;
					if (s_q.cnt == 2'h1)
						s_d.sup_sp = {s_q.fetch,
							bus_rsp_i.rdata};
					if (s_q.cnt == 2'h3)
					begin
						s_d.pc = {s_q.fetch, bus_rsp_i.rdata};
						s_d.resume = 1'b1;
						s_d.pc_load = 1'b1;
						s_d.t_arm = s_q.sw[exc_pkg::SW_T];
						s_d.st = exc_pkg::ST_IDLE;
					end
				end
			end
			exc_pkg::ST_IDLE:
			begin
				if (addr_err_i || bus_err_i)
				begin
					// Aborted work is never traced
					s_d.trace_pend = 1'b0;
					s_d.trap_pend = 1'b0;
					s_d.t_arm = 1'b0;
					s_d.pc = bnd_i.pc;
					s_d = enter(s_d, addr_err_i ? exc_pkg::VEC_ADDR_ERR
						: exc_pkg::VEC_BUS_ERR,
						exc_pkg::FMT_LONG);
				end
				else if (bnd_i.valid)
				begin
					s_d.trap_pend = bnd_i.trap_req;
					s_d.trap_vec = bnd_i.trap_vec;
					s_d.trace_pend = s_q.t_arm
						&& bnd_i.executed;
					s_d.t_arm = 1'b0;
					s_d.pc = bnd_i.pc;
					s_d.op = bnd_i.opcode;
					s_d.op_bad = bnd_i.bad;
					s_d.taken = 1'b0;
					s_d.st = exc_pkg::ST_DECIDE;
				end
			end
			exc_pkg::ST_DECIDE:
			begin
				if (s_q.trap_pend)
				begin
					s_d.trap_pend = 1'b0;
					s_d = enter(s_d, s_q.trap_vec,
						exc_pkg::FMT_SHORT);
				end
				else if (s_q.trace_pend)
				begin
					s_d.trace_pend = 1'b0;
					s_d = enter(s_d, exc_pkg::VEC_TRACE,
						exc_pkg::FMT_SHORT);
				end
				else if (irq_take)
				begin
					s_d = enter(s_d, 8'h00, exc_pkg::FMT_SHORT);
					s_d.ack_lvl = s_q.nmi_pend ? exc_pkg::LVL_MAX : lvl;
					s_d.sw[exc_pkg::SW_MASK +: 3] = s_d.ack_lvl;
					if (s_d.ack_lvl == exc_pkg::LVL_MAX)
						s_d.nmi_pend = 1'b0;
					s_d.st = exc_pkg::ST_IACK;
				end
				else if (s_q.taken)
				begin
					s_d.resume = 1'b1;
					s_d.pc_load = 1'b1;
					s_d.t_arm = s_q.sw[exc_pkg::SW_T];
					s_d.st = exc_pkg::ST_IDLE;
				end
				else if (op_bkpt)
				begin
					s_d = enter(s_d, exc_pkg::VEC_ILLEGAL,
						exc_pkg::FMT_SHORT);
					s_d.st = exc_pkg::ST_BKPT;
				end
				else if (op_ill)
					s_d = enter(s_d, exc_pkg::VEC_ILLEGAL,
						exc_pkg::FMT_SHORT);
				else if (s_q.op[15:12] == 4'ha)
					s_d = enter(s_d, exc_pkg::VEC_LINE_A,
						exc_pkg::FMT_SHORT);
				else if (s_q.op[15:12] == 4'hf)
					s_d = enter(s_d, exc_pkg::VEC_LINE_F,
						exc_pkg::FMT_SHORT);
				else if (op_priv && !s_q.sw[exc_pkg::SW_S])
					s_d = enter(s_d, exc_pkg::VEC_PRIV,
						exc_pkg::FMT_SHORT);
				else if (s_q.op == exc_pkg::OP_RESET)
				begin
					s_d.ext_reset = 1'b1;
					s_d.rst_cnt = 8'(RESET_PULSE_CYC - 1);
					s_d.st = exc_pkg::ST_EXTRST;
				end
				else
				begin
					s_d.resume = 1'b1;
					s_d.t_arm = s_q.sw[exc_pkg::SW_T];
					s_d.st = exc_pkg::ST_IDLE;
				end
			end
			exc_pkg::ST_IACK:
			begin
				if (!s_q.bus.req)
				begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b0;
					s_d.bus.kind = exc_pkg::KIND_IACK;
					s_d.bus.addr = exc_pkg::IACK_ADDR & ~32'he
						| {28'h0, s_q.ack_lvl, 1'b0};
				end
				else if (bus_rsp_i.done)
				begin
					s_d.bus.req = 1'b0;
					s_d.st = exc_pkg::ST_PUSH;
					unique case (bus_rsp_i.term)
						exc_pkg::TERM_AUTOVEC: s_d.vec =
							exc_pkg::VEC_AUTO_BASE
							+ {5'h0, s_q.ack_lvl};
						exc_pkg::TERM_BUS_FAULT: s_d.vec =
							exc_pkg::VEC_SPURIOUS;
						default: s_d.vec =
							bus_rsp_i.rdata[7:0];
					endcase
				end
			end
			exc_pkg::ST_BKPT:
			begin
				// Any termination ends the cycle; no data is used
				if (!s_q.bus.req)
				begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b0;
					s_d.bus.kind = exc_pkg::KIND_BKPT;
					s_d.bus.addr = s_q.pc;
				end
				else if (bus_rsp_i.done)
				begin
					s_d.bus.req = 1'b0;
					s_d.st = exc_pkg::ST_PUSH;
				end
			end
			exc_pkg::ST_PUSH:
			begin
				if (!s_q.bus.req)
				begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b1;
					s_d.bus.kind = exc_pkg::KIND_DATA;
					s_d.bus.addr = s_q.sup_sp - 32'h2;
					unique case (s_q.cnt)
						2'h0: s_d.bus.wdata = {s_q.fmt, 2'h0,
							s_q.vec, 2'h0};
						2'h1: s_d.bus.wdata = s_q.pc[15:0];
						2'h2: s_d.bus.wdata = s_q.pc[31:16];
						default: s_d.bus.wdata = s_q.sw_copy;
					endcase
				end
				else if (bus_rsp_i.done)
				begin
					s_d.bus.req = 1'b0;
					s_d.sup_sp = s_q.sup_sp - 32'h2;
					s_d.cnt = s_q.cnt + 2'h1;
					if (s_q.cnt == 2'h3)
						s_d.st = exc_pkg::ST_VEC;
				end
			end
			exc_pkg::ST_VEC:
			begin
				if (!s_q.bus.req)
				begin
					s_d.bus.req = 1'b1;
					s_d.bus.we = 1'b0;
					s_d.bus.kind = exc_pkg::KIND_DATA;
					s_d.bus.addr = s_q.vbr + {22'h0, s_q.vec, 2'h0}
						+ {30'h0, s_q.cnt[0], 1'b0};
				end
				else if (bus_rsp_i.done)
				begin
					s_d.bus.req = 1'b0;
					s_d.fetch = bus_rsp_i.rdata;
					s_d.cnt = s_q.cnt + 2'h1;
					if (s_q.cnt == 2'h1)
					begin
						s_d.pc = {s_q.fetch, bus_rsp_i.rdata};
						s_d.st = exc_pkg::ST_DECIDE;
					end
				end
			end
			exc_pkg::ST_EXTRST:
			begin
				s_d.rst_cnt = s_q.rst_cnt - 8'h1;
				if (s_q.rst_cnt == 8'h0)
				begin
					s_d.ext_reset = 1'b0;
					s_d.resume = 1'b1;
					s_d.t_arm = s_q.sw[exc_pkg::SW_T];
					s_d.st = exc_pkg::ST_IDLE;
				end
			end
			default: s_d.st = exc_pkg::ST_RSTVEC;
		endcase
		// Edge to seven is caught after the clear, so it is never lost;
		// an edge accepted in this very cycle is not entered twice
		if (lvl == exc_pkg::LVL_MAX && s_q.lvl_prev != exc_pkg::LVL_MAX
			&& !(s_q.st == exc_pkg::ST_DECIDE
			&& s_d.st == exc_pkg::ST_IACK
			&& s_d.ack_lvl == exc_pkg::LVL_MAX))
			s_d.nmi_pend = 1'b1;
		s_d.lvl_prev = lvl;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
		begin
			s_q <= '0;
			s_q.st <= exc_pkg::ST_RSTVEC;
			s_q.sw <= exc_pkg::SW_RESET;
			s_q.vbr <= exc_pkg::VBR_RESET;
			s_q.lvl_prev <= exc_pkg::LVL_MAX;
			s_q.waitreq <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign bus_req_o = s_q.bus;
	assign resume_o = s_q.resume;
	assign pc_load_o = s_q.pc_load;
	assign pc_o = s_q.pc;
	assign ext_reset_o = s_q.ext_reset;
	assign avs_readdata_o = s_q.rdata;
	assign avs_waitrequest_o = s_q.waitreq;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!resetn_i);

	sequence s_iack_end(exc_pkg::term_e t);
		s_q.st == exc_pkg::ST_IACK && rsp_done && bus_rsp_i.term == t;
	endsequence

	sequence s_accept;
		$rose(s_q.st == exc_pkg::ST_IACK);
	endsequence

	property p_reset_state;
		$rose(resetn_i) |-> s_q.sw == exc_pkg::SW_RESET
			&& s_q.vbr == exc_pkg::VBR_RESET
			&& s_q.st == exc_pkg::ST_RSTVEC;
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("reset state wrong");

	property p_reset_load;
		(s_q.st == exc_pkg::ST_RSTVEC && rsp_done && s_q.cnt == 2'h3)
			|=> s_q.resume && s_q.pc_load && !s_q.bus.we
			&& s_q.pc[15:0] == $past(bus_rsp_i.rdata);
	endproperty
	a_reset_load: assert property (p_reset_load)
		else $error("reset vector load wrong");

	property p_accept;
		s_accept |-> $past(s_q.st) == exc_pkg::ST_DECIDE
			&& s_q.sw[exc_pkg::SW_S] && !s_q.sw[exc_pkg::SW_T]
			&& s_q.sw[exc_pkg::SW_MASK +: 3] == s_q.ack_lvl
			&& s_q.sw_copy == $past(s_q.sw);
	endproperty
	a_accept: assert property (p_accept)
		else $error("interrupt accept wrong");

	property p_iack_cycle;
		(s_q.st == exc_pkg::ST_IACK && s_q.bus.req)
			|-> s_q.bus.kind == exc_pkg::KIND_IACK
			&& s_q.bus.addr[3:1] == s_q.ack_lvl;
	endproperty
	a_iack_cycle: assert property (p_iack_cycle)
		else $error("acknowledge cycle wrong");

	property p_autovec;
		s_iack_end(exc_pkg::TERM_AUTOVEC) |=> s_q.vec
			== exc_pkg::VEC_AUTO_BASE + {5'h0, s_q.ack_lvl};
	endproperty
	a_autovec: assert property (p_autovec)
		else $error("autovector wrong");

	property p_spurious;
		s_iack_end(exc_pkg::TERM_BUS_FAULT) |=> s_q.vec
			== exc_pkg::VEC_SPURIOUS && s_q.fmt == exc_pkg::FMT_SHORT;
	endproperty
	a_spurious: assert property (p_spurious)
		else $error("spurious vector wrong");

	property p_nmi_edge;
		(lvl == exc_pkg::LVL_MAX && s_q.lvl_prev != exc_pkg::LVL_MAX)
			|=> s_q.nmi_pend || s_q.st == exc_pkg::ST_IACK;
	endproperty
	a_nmi_edge: assert property (p_nmi_edge)
		else $error("level seven edge lost");

	property p_abort;
		(s_q.st == exc_pkg::ST_IDLE && addr_err_i) |=> ##[0:1]
			(s_q.st == exc_pkg::ST_PUSH && !s_q.trace_pend
			&& s_q.vec == exc_pkg::VEC_ADDR_ERR);
	endproperty
	a_abort: assert property (p_abort)
		else $error("abort entry late");

	property p_ext_reset;
		$rose(s_q.ext_reset) |-> (s_q.ext_reset && !s_q.resume) [*8];
	endproperty
	a_ext_reset: assert property (p_ext_reset)
		else $error("external reset pulse short");
endmodule

// ==== inc/exc_pkg.sv ====
package exc_pkg;
	// Register byte offsets on the Avalon slave
	localparam logic [7:0]  REG_STATUS    = 8'h00;
	localparam logic [7:0]  REG_VBR       = 8'h04;
	localparam logic [7:0]  REG_SUP_SP    = 8'h08;
	localparam logic [7:0]  REG_INFO      = 8'h0c;

	// Status word fields and values after reset
	localparam int          SW_T          = 15;
	localparam int          SW_S          = 13;
	localparam int          SW_MASK       = 8;
	localparam logic [15:0] SW_RESET      = 16'h2700;
	localparam logic [31:0] VBR_RESET     = 32'h0000_0000;
	localparam logic [31:0] RST_VEC_ADDR  = 32'h0000_0000;
	localparam logic [2:0]  LVL_MAX       = 3'h7;

	// Vector numbers and frame formats
	localparam logic [7:0]  VEC_BUS_ERR   = 8'h02;
	localparam logic [7:0]  VEC_ADDR_ERR  = 8'h03;
	localparam logic [7:0]  VEC_ILLEGAL   = 8'h04;
	localparam logic [7:0]  VEC_PRIV      = 8'h08;
	localparam logic [7:0]  VEC_TRACE     = 8'h09;
	localparam logic [7:0]  VEC_LINE_A    = 8'h0a;
	localparam logic [7:0]  VEC_LINE_F    = 8'h0b;
	localparam logic [7:0]  VEC_SPURIOUS  = 8'h18;
	localparam logic [7:0]  VEC_AUTO_BASE = 8'h18;
	localparam logic [3:0]  FMT_SHORT     = 4'h0;
	localparam logic [3:0]  FMT_LONG      = 4'h8;
	localparam logic [31:0] IACK_ADDR     = 32'hffff_fff1;

	// Opcode patterns
	localparam logic [15:0] OP_BKPT       = 16'h4848;
	localparam logic [15:0] OP_ILL_LO     = 16'h4afa;
	localparam logic [15:0] OP_ILL_HI     = 16'h4afc;
	localparam logic [15:0] OP_AND_SW     = 16'h027c;
	localparam logic [15:0] OP_EOR_SW     = 16'h0a7c;
	localparam logic [15:0] OP_OR_SW      = 16'h007c;
	localparam logic [15:0] OP_TO_SW      = 16'h46c0;
	localparam logic [15:0] OP_FROM_SW    = 16'h40c0;
	localparam logic [15:0] OP_CTRL_MOVE  = 16'h4e7a;
	localparam logic [15:0] OP_ALT_MOVE   = 16'h0e00;
	localparam logic [15:0] OP_USTK_MOVE  = 16'h4e60;
	localparam logic [15:0] OP_RESET      = 16'h4e70;
	localparam logic [15:0] OP_STOP       = 16'h4e72;
	localparam logic [15:0] OP_EXC_RETURN = 16'h4e73;

	// Length of the external reset pulse in core cycles
	localparam int          EXT_RESET_CYC = 124;

	typedef enum logic [8:0] {
		ST_RSTVEC = 9'h001,
		ST_IDLE   = 9'h002,
		ST_DECIDE = 9'h004,
		ST_IACK   = 9'h008,
		ST_BKPT   = 9'h010,
		ST_PUSH   = 9'h020,
		ST_VEC    = 9'h040,
		ST_EXTRST = 9'h080,
		ST_SPARE  = 9'h100
	} state_e;

	typedef enum logic [1:0] {
		TERM_XFER_ACK  = 2'h0,
		TERM_AUTOVEC   = 2'h1,
		TERM_BUS_FAULT = 2'h2
	} term_e;

	typedef enum logic [1:0] {
		KIND_DATA = 2'h0,
		KIND_IACK = 2'h1,
		KIND_BKPT = 2'h2
	} kind_e;

	typedef struct packed {
		logic        req;
		logic        we;
		kind_e       kind;
		logic [31:0] addr;
		logic [15:0] wdata;
	} bus_req_s;

	typedef struct packed {
		logic        done;
		term_e       term;
		logic [15:0] rdata;
	} bus_rsp_s;

	typedef struct packed {
		logic        valid;
		logic        executed;
		logic        bad;
		logic [15:0] opcode;
		logic [31:0] pc;
		logic        trap_req;
		logic [7:0]  trap_vec;
	} bnd_s;
endpackage

// ==== src/irq_level_sync.sv ====
`timescale 1ns/1ps
module irq_level_sync #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         resetn_i,
	// Level from the pins and its settled copy
	input  wire logic [W-1:0] level_i,
	output logic      [W-1:0] level_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] prev;
		logic [W-1:0] stable;
	} sync_s;

	sync_s s_q;
	sync_s s_d;

	// A level is passed on only once two synced samples agree, so a
	// skewed change of the encoded lines never shows a false level
	always_comb
	begin
		s_d = s_q;
		s_d.meta = level_i;
		s_d.sync = s_q.meta;
		s_d.prev = s_q.sync;
		if (s_q.sync == s_q.prev)
			s_d.stable = s_q.sync;
	end

	always_ff @(posedge core_clk_i)
	begin
		if (!resetn_i)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign level_o = s_q.stable;
endmodule

// ==== dv/irq_source_model.sv ====
`timescale 1ns/1ps
module irq_source_model (
	// Clock and reset
	input  wire logic         core_clk_i,
	input  wire logic         resetn_i,
	// Bus unit port of the sequencer
	input  exc_pkg::bus_req_s req_i,
	output exc_pkg::bus_rsp_s rsp_o,
	// Answer chosen by the bench
	input  wire logic [1:0]   term_i,
	input  wire logic [7:0]   vec_i,
	input  wire logic [2:0]   wait_i
);
	logic [2:0] cnt_q;
	logic       held_q;

	always_ff @(posedge core_clk_i)
	begin
		// Released data lines wander so a stale word is never trusted
		rsp_o.rdata <= ~rsp_o.rdata;
		rsp_o.done  <= 1'b0;
		if (!resetn_i)
			rsp_o <= '0;
		if (!resetn_i || !req_i.req)
		begin
			cnt_q  <= 3'h0;
			held_q <= 1'b0;
		end
		else if (!held_q && cnt_q != wait_i)
			cnt_q <= cnt_q + 3'h1;
		else if (!held_q)
		begin
			held_q      <= 1'b1;
			rsp_o.done  <= 1'b1;
			rsp_o.term  <= exc_pkg::TERM_XFER_ACK;
			rsp_o.rdata <= req_i.addr[15:0] ^ 16'h5a00;
			if (req_i.kind != exc_pkg::KIND_DATA)
			begin
				rsp_o.term  <= exc_pkg::term_e'(term_i);
				rsp_o.rdata <= {8'ha5, vec_i};
			end
		end
	end
endmodule

// ==== dv/tb_exc_sequencer.sv ====
`timescale 1ns/1ps
module tb_exc_sequencer;
	localparam int PULSE = 8;
	logic              core_clk_i;
	logic              resetn_i;
	logic [2:0]        irq;
	exc_pkg::bnd_s     bnd;
	logic              aerr;
	logic              bus_fault_input;
	exc_pkg::bus_req_s breq;
	exc_pkg::bus_rsp_s brsp;
	logic              resume;
	logic              pc_load;
	logic [31:0]       pc;
	logic              ext_rst;
	logic [7:0]        adr;
	logic              rd;
	logic              wr;
	logic [31:0]       wdat;
	logic [31:0]       rdat;
	logic              wait_req;
	logic [1:0]        term;
	logic [7:0]        ivec;
	logic [2:0]        slow;
	logic [31:0]       vbr;
	logic [31:0]       got;
	logic [31:0]       pcv;
	logic              loaded;
	int                bad_count;
	int                total_checks;
	int                cyc;
	int                nvec;
	int                rst_len;

	exc_sequencer #(.RESET_PULSE_CYC(PULSE)) i_dut (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .irq_level_i(irq),
		.bnd_i(bnd), .addr_err_i(aerr), .bus_err_i(bus_fault_input),
		.bus_req_o(breq), .bus_rsp_i(brsp), .resume_o(resume),
		.pc_load_o(pc_load), .pc_o(pc), .ext_reset_o(ext_rst),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
		.avs_byteenable_i(4'hf), .avs_writedata_i(wdat),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wait_req));

	irq_source_model i_src (
		.core_clk_i(core_clk_i), .resetn_i(resetn_i), .req_i(breq),
		.rsp_o(brsp), .term_i(term), .vec_i(ivec), .wait_i(slow));

	initial
	begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = ~core_clk_i;
	end

	task automatic stop_test;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Counts vector fetches (even word of each pair) and reset pulse length
	always @(posedge core_clk_i)
	begin
		cyc++;
		if (ext_rst === 1'b1)
			rst_len++;
		if (brsp.done === 1'b1 && breq.req === 1'b1 && breq.we === 1'b0 &&
			breq.addr[1] === 1'b0 && breq.kind === exc_pkg::KIND_DATA)
			nvec++;
		if (cyc == 20000)
		begin
			bad_count++;
			stop_test();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask

	task automatic av(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		adr  <= a;
		wr   <= w;
		rd   <= !w;
		wdat <= d;
		do
			@(posedge core_clk_i);
		while (wait_req !== 1'b0);
		got = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge core_clk_i);
	endtask

	task automatic wait_resume;
		do
			@(posedge core_clk_i);
		while (resume !== 1'b1);
		loaded = pc_load;
		pcv    = pc;
	endtask

	function automatic logic [31:0] vpc(input logic [7:0] v);
		logic [15:0] a;
		a = vbr[15:0] + {6'h0, v, 2'h0};
		return {a ^ 16'h5a00, (a + 16'h2) ^ 16'h5a00};
	endfunction

	task automatic run(input logic [15:0] op, input logic [1:0] ex,
		input logic [7:0] tv, input logic [15:0] sw, input logic [2:0] lv,
		input logic [1:0] tm, input logic [7:0] iv, input logic [1:0] ab,
		input int n, input logic [7:0] ev);
		logic [2:0] em;
		em = (lv != 3'h0 && n != 0) ? lv : sw[10:8];
		av(1'b1, exc_pkg::REG_STATUS, {16'h0, sw});
		// Trace arms at resume, so one unexecuted boundary picks up the new T
		bnd <= '{1'b1, 1'b0, 1'b0, 16'h4e71, 32'h2000, 1'b0, 8'h00};
		@(posedge core_clk_i);
		bnd.valid <= 1'b0;
		wait_resume;
		chk({31'h0, loaded}, 32'h0);
		irq  <= lv;
		term <= tm;
		ivec <= iv;
		slow <= slow + 3'h1;
		repeat (16) @(posedge core_clk_i);
		nvec    = 0;
		rst_len = 0;
		if (ab != 2'h0)
		begin
			aerr <= ab[1];
			bus_fault_input <= ab[0];
		end
		else
			bnd <= '{1'b1, ex[0], ex[1], op, 32'h2000, tv != 8'h0, tv};
		@(posedge core_clk_i);
		aerr      <= 1'b0;
		bus_fault_input      <= 1'b0;
		bnd.valid <= 1'b0;
		wait_resume;
		chk(32'(nvec), 32'(n));
		chk({31'h0, loaded}, {31'h0, n != 0});
		if (n != 0)
		begin
			chk(pcv, vpc(ev));
			av(1'b0, exc_pkg::REG_STATUS, 32'h0);
			chk(got & 32'ha700, {16'h0, 5'h04, em, 8'h00});
		end
		if (op == exc_pkg::OP_RESET && n == 0)
			chk(32'(rst_len), 32'(PULSE));
		irq <= 3'h0;
		repeat (16) @(posedge core_clk_i);
	endtask

	initial
	begin
		resetn_i     = 1'b0;
		irq          = 3'h0;
		bnd          = '0;
		aerr         = 1'b0;
		bus_fault_input         = 1'b0;
		adr          = 8'h00;
		rd           = 1'b0;
		wr           = 1'b0;
		wdat         = 32'h0;
		term         = 2'h0;
		ivec         = 8'h00;
		slow         = 3'h0;
		vbr          = 32'h0;
		bad_count    = 0;
		total_checks = 0;
		cyc          = 0;
		nvec         = 0;
		rst_len      = 0;
		repeat (20) @(posedge core_clk_i);
		resetn_i <= 1'b1;
		wait_resume;
		chk(pcv, vpc(8'h01));
		av(1'b0, exc_pkg::REG_SUP_SP, 32'h0);
		chk(got, vpc(8'h00));
		av(1'b0, exc_pkg::REG_STATUS, 32'h0);
		chk(got, 32'h0000_2700);
		av(1'b0, exc_pkg::REG_VBR, 32'h0);
		chk(got, 32'h0);
		av(1'b0, 8'h10, 32'h0);
		chk(got, 32'h0);
		vbr = 32'h0000_1000;
		av(1'b1, exc_pkg::REG_VBR, vbr);
		av(1'b0, exc_pkg::REG_VBR, 32'h0);
		chk(got, vbr);
		run(16'h4afc,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h04);
		run(16'h4afa,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h04);
		run(16'h4e71,2'h3,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h04);
		run(16'h4848,2'h1,8'h00,16'h2000,3'h0,2'h2,8'h00,2'h0,1,8'h04);
		run(16'h484f,2'h1,8'h00,16'h2000,3'h0,2'h1,8'h00,2'h0,1,8'h04);
		run(16'ha123,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h0a);
		run(16'hf456,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h0b);
		run(16'h4e70,2'h1,8'h00,16'h0000,3'h0,2'h0,8'h00,2'h0,1,8'h08);
		run(16'h4e73,2'h1,8'h00,16'h0000,3'h0,2'h0,8'h00,2'h0,1,8'h08);
		run(16'h4e71,2'h1,8'h20,16'h2000,3'h0,2'h0,8'h00,2'h0,1,8'h20);
		run(16'h4e71,2'h1,8'h00,16'ha000,3'h0,2'h0,8'h00,2'h0,1,8'h09);
		run(16'h4e71,2'h0,8'h00,16'ha000,3'h0,2'h0,8'h00,2'h0,0,8'h00);
		run(16'h4e70,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h0,0,8'h00);
		run(16'h4e71,2'h1,8'h00,16'h2300,3'h3,2'h0,8'h00,2'h0,0,8'h00);
		run(16'h4e71,2'h1,8'h00,16'h2300,3'h5,2'h1,8'h00,2'h0,1,8'h1d);
		run(16'h4e71,2'h1,8'h00,16'h2200,3'h4,2'h0,8'h40,2'h0,1,8'h40);
		run(16'h4e71,2'h1,8'h00,16'h2000,3'h2,2'h0,8'h0f,2'h0,1,8'h0f);
		run(16'h4e71,2'h1,8'h00,16'h2000,3'h6,2'h2,8'h00,2'h0,1,8'h18);
		run(16'h4e71,2'h1,8'h00,16'h2700,3'h7,2'h0,8'h41,2'h0,1,8'h41);
		run(16'h4e71,2'h1,8'h20,16'ha300,3'h5,2'h1,8'h00,2'h0,3,8'h1d);
		run(16'h4e71,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h1,1,8'h02);
		run(16'h4e71,2'h1,8'h00,16'h2000,3'h0,2'h0,8'h00,2'h3,1,8'h03);
		stop_test();
	end
endmodule
